/* File: verilog/wdt_top.sv */
// watchdog / interval timer with its two byte registers
`timescale 1ns/1ns
module wdt_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic wr_en,
   input wire logic bit_wr,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] wdata,
   input wire logic rd_en,
   output logic [7:0] rdata_q,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic sub_clk_cpu,
   input wire logic watchdog_irq_flag,
   input wire logic watchdog_irq_mask,
   output logic interval_overflow_irq_q,
   output logic nmi_req_q,
   output logic sys_reset_req_q
);
   logic [7:0] ccs_q;
   logic [7:0] mrr_q;
   logic [9:0] presc_q;
   logic [6:0] count_q;
   logic [1:0] stop_s_q;
   logic [1:0] sub_s_q;
   logic [1:0] flag_s_q;
   logic [9:0] presc_prev_q;

   // register decode; write-once bits merge with held value
   wire ccs_hit = addr == wdt_pkg::WDT_CCS_ADDR;
   wire mrr_hit = addr == wdt_pkg::WDT_MRR_ADDR;
   wire ccs_wr = wr_en && ccs_hit && !bit_wr;
   wire mrr_wr = wr_en && mrr_hit;
   wire [7:0] bit_val = 8'h01 << bit_sel;
   wire [7:0] mrr_wval = bit_wr ? (wdata[0] ? (mrr_q | bit_val) : (mrr_q & ~bit_val)) : wdata;
   // write-once storage: an implemented bit may go from 0 to 1, never back
   wire [7:0] mrr_d;
   genvar gb;
   generate
      for (gb = 0; gb < 8; gb++)
      begin : g_mrr_bit
         // unused positions drop whatever is written
         assign mrr_d[gb] = wdt_pkg::WDT_MRR_MASK[gb] && (mrr_q[gb] || mrr_wval[gb]);
      end
   endgenerate
   // a bit write names one bit, so only a write aimed at run restarts the count;
   // otherwise setting a mode bit while running would quietly kick the watchdog
   wire bit_run_set = bit_wr && (bit_sel == 3'(wdt_pkg::WDT_RUN_POS)) && wdata[0];
   wire byte_run_set = !bit_wr && wdata[wdt_pkg::WDT_RUN_POS];
   wire run_write = mrr_wr && (bit_run_set || byte_run_set);
   wire [1:0] mode = {mrr_q[wdt_pkg::WDT_MODE_HIGH_POS], mrr_q[wdt_pkg::WDT_MODE_LOW_POS]};
   wire [1:0] clk_sel = {ccs_q[wdt_pkg::WDT_CLK_SEL_HIGH_POS], ccs_q[wdt_pkg::WDT_CLK_SEL_LOW_POS]};
   wire running = mrr_q[wdt_pkg::WDT_RUN_POS] && (mode != wdt_pkg::WDT_MODE_STOP);
   // halt keeps counting; stop or subsystem cpu clock freezes it
   wire frozen = stop_s_q[1] || sub_s_q[1];
   // halt_mode is not read: the counter simply runs on in halt
   // divide by 16/64/256/1024: taps two prescaler bits apart, one edge detector each;
   // edges come from the delayed copy, so a frozen prescaler gives no edge at all
   wire [3:0] tap_rise;
   genvar gt;
   generate
      for (gt = 0; gt < 4; gt++)
      begin : g_tap
         localparam int TAP_BIT = wdt_pkg::WDT_TAP0 + 2 * gt;
         assign tap_rise[gt] = presc_q[TAP_BIT] && !presc_prev_q[TAP_BIT];
      end
   endgenerate
   wire tick = tap_rise[clk_sel] && !frozen;
   // 128 ticks of the chosen tap make 2^11/2^13/2^15/2^17 clocks;
   // an overflow in the very cycle of a restart still fires: the kick came too late
   wire ovf = running && tick && (count_q == wdt_pkg::WDT_COUNT_LAST);
   // only the write that first sets the watchdog bit can raise the late request
   wire wd_mode_now = mrr_d[wdt_pkg::WDT_MODE_HIGH_POS] && !mrr_q[wdt_pkg::WDT_MODE_HIGH_POS];
   wire late_nmi = mrr_wr && wd_mode_now && flag_s_q[1];

   // input synchronisers for levels from outside
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stop_s_q <= 2'h0;
         sub_s_q <= 2'h0;
         flag_s_q <= 2'h0;
      end
      else
      begin
         stop_s_q <= {stop_s_q[0], stop_mode};
         sub_s_q <= {sub_s_q[0], sub_clk_cpu};
         flag_s_q <= {flag_s_q[0], watchdog_irq_flag};
      end
   end

   // registers; reset clears both
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ccs_q <= wdt_pkg::WDT_CCS_RESET;
         mrr_q <= wdt_pkg::WDT_MRR_RESET;
      end
      else
      begin
         if (ccs_wr)
            ccs_q <= wdata & wdt_pkg::WDT_CCS_MASK;
         if (mrr_wr)
            mrr_q <= mrr_d;
      end
   end

   // free-running prescaler, never cleared by a restart
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         presc_q <= 10'h000;
         presc_prev_q <= 10'h000;
      end
      else
      begin
         presc_prev_q <= presc_q;
         if (!frozen)
            presc_q <= presc_q + 10'h001;
      end
   end

   // main counter; run write clears it, overflow wraps for interval use
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count_q <= 7'h00;
      else if (run_write)
         count_q <= 7'h00;
      else if (running && tick)
         count_q <= count_q + 7'h01;
   end

   // overflow outputs by mode, one-cycle pulses
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         interval_overflow_irq_q <= 1'b0;
         nmi_req_q <= 1'b0;
         sys_reset_req_q <= 1'b0;
      end
      else
      begin
         // mask gates only the interval interrupt
         interval_overflow_irq_q <= ovf && mode == wdt_pkg::WDT_MODE_INTERVAL
            && !watchdog_irq_mask;
         nmi_req_q <= (ovf && mode == wdt_pkg::WDT_MODE_NMI) || late_nmi;
         sys_reset_req_q <= ovf && mode == wdt_pkg::WDT_MODE_RESET;
      end
   end

   // read path; unused bits are already zero in storage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else if (rd_en)
         rdata_q <= ccs_hit ? ccs_q : (mrr_hit ? mrr_q : 8'h00);
   end
endmodule

/* File: verilog/wdt_pkg.sv */
// constants of the watchdog / interval timer
// Operation
// - runaway detection: expiry without restart gives non-maskable interrupt or reset
// - overflow period selectable as 2^11, 2^13, 2^15 or 2^17 main clocks
// - interval mode raises an interrupt repeatedly at every overflow period
// - count clock select codes 00..11 pick main clock divided by 16/64/256/1024
// - reset clears both registers to zero; timer is stopped
// - mode/run register accepts single-bit and whole-byte writes
// - writing run bit 1 clears counter and starts counting; 0 means stopped
// - once run is 1, writing 0 has no effect; only reset stops it
// - mode 00 stop, 01 interval, 10 watchdog nmi, 11 watchdog reset
// - each mode bit once set ignores clears until reset
// - interval timing begins only when run bit is written with 1
// - first overflow after restart may be early; prescaler phase kept
// - watchdog mode written while irq flag is 1 raises nmi at write completion
// - interval interrupt gated by mask flag, highest maskable priority
// - counter runs in halt, stops in stop, stops when subsystem clock drives cpu
package wdt_pkg;
   localparam logic [15:0] WDT_CCS_ADDR = 16'hff42;
   localparam logic [15:0] WDT_MRR_ADDR = 16'hfff9;
   localparam logic [7:0] WDT_CCS_RESET = 8'h00;
   localparam logic [7:0] WDT_MRR_RESET = 8'h00;
   localparam int WDT_CLK_SEL_LOW_POS = 1;
   localparam int WDT_CLK_SEL_HIGH_POS = 2;
   localparam int WDT_MODE_LOW_POS = 3;
   localparam int WDT_MODE_HIGH_POS = 4;
   localparam int WDT_RUN_POS = 7;
   localparam logic [7:0] WDT_CCS_MASK = 8'h06;
   localparam logic [7:0] WDT_MRR_MASK = 8'h98;
   localparam int WDT_PRESCALE_W = 10;
   localparam int WDT_COUNT_W = 7;
   localparam int WDT_TAP0 = 3;
   localparam logic [6:0] WDT_COUNT_LAST = 7'h7f;
   localparam logic [1:0] WDT_MODE_STOP = 2'h0;
   localparam logic [1:0] WDT_MODE_INTERVAL = 2'h1;
   localparam logic [1:0] WDT_MODE_NMI = 2'h2;
   localparam logic [1:0] WDT_MODE_RESET = 2'h3;
endpackage

/* File: dv/wdt_top_sva.sv */
// port-level checks of the watchdog / interval timer
`timescale 1ns/1ns
module wdt_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic rd_en,
   input wire logic [7:0] rdata_q,
   input wire logic stop_mode,
   input wire logic sub_clk_cpu,
   input wire logic watchdog_irq_mask,
   input wire logic interval_overflow_irq_q,
   input wire logic nmi_req_q,
   input wire logic sys_reset_req_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // overflow events are single pulses, interval and reset ones at least 8 cycles apart
   AST_IRQ_GAP: assert property (interval_overflow_irq_q |=> !interval_overflow_irq_q[*8])
      else $error("interval pulse too long");
   AST_SRST_GAP: assert property (sys_reset_req_q |=> !sys_reset_req_q[*8])
      else $error("reset request too long");
   AST_NMI_PULSE: assert property (nmi_req_q |=> !nmi_req_q)
      else $error("nmi too long");
   AST_ONE_EVENT: assert property ($onehot0({interval_overflow_irq_q, sys_reset_req_q}))
      else $error("two events at once");
   AST_MASKED: assert property (watchdog_irq_mask && $past(watchdog_irq_mask) |-> !interval_overflow_irq_q)
      else $error("masked interrupt seen");
   // sync delay of stop is two flops, so five cycles is safe
   AST_FROZEN: assert property (stop_mode[*5] |-> !interval_overflow_irq_q && !sys_reset_req_q)
      else $error("overflow while stopped");
   AST_SUB_FROZEN: assert property (sub_clk_cpu[*5] |-> !interval_overflow_irq_q
      && !sys_reset_req_q)
      else $error("overflow on subsystem clock");
   AST_UNMAPPED: assert property (rd_en && addr != wdt_pkg::WDT_CCS_ADDR
      && addr != wdt_pkg::WDT_MRR_ADDR |=> rdata_q == 8'h00)
      else $error("unmapped read not zero");
   AST_CCS_BITS: assert property (rd_en && addr == wdt_pkg::WDT_CCS_ADDR
      |=> (rdata_q & ~wdt_pkg::WDT_CCS_MASK) == 8'h00)
      else $error("clock select spare bits set");
endmodule
bind wdt_top wdt_top_sva chk (
   .clk(clk),
   .rst(rst),
   .addr(addr),
   .rd_en(rd_en),
   .rdata_q(rdata_q),
   .stop_mode(stop_mode),
   .sub_clk_cpu(sub_clk_cpu),
   .watchdog_irq_mask(watchdog_irq_mask),
   .interval_overflow_irq_q(interval_overflow_irq_q),
   .nmi_req_q(nmi_req_q),
   .sys_reset_req_q(sys_reset_req_q)
);

/* File: dv/wdt_top_bench.sv */
// self-checking bench for the watchdog / interval timer
`timescale 1ns/1ns
`define CHK(n, e, a) samples_checked++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %s exp %h got %h", n, e, a); end
module wdt_top_bench;
   logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, bit_wr = 0, halt_mode = 0, stop_mode = 0;
   logic sub_clk_cpu = 0, watchdog_irq_flag = 0, watchdog_irq_mask = 0, seen;
   logic [2:0] bit_sel = 3'h0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata_q;
   logic interval_overflow_irq_q, nmi_req_q, sys_reset_req_q;
   int failures = 0, samples_checked = 0, n;
   wdt_top dut (
      .clk(clk),
      .rst(rst),
      .addr(addr),
      .wr_en(wr_en),
      .bit_wr(bit_wr),
      .bit_sel(bit_sel),
      .wdata(wdata),
      .rd_en(rd_en),
      .rdata_q(rdata_q),
      .halt_mode(halt_mode),
      .stop_mode(stop_mode),
      .sub_clk_cpu(sub_clk_cpu),
      .watchdog_irq_flag(watchdog_irq_flag),
      .watchdog_irq_mask(watchdog_irq_mask),
      .interval_overflow_irq_q(interval_overflow_irq_q),
      .nmi_req_q(nmi_req_q),
      .sys_reset_req_q(sys_reset_req_q)
   );
   initial forever #25 clk = ~clk;
   task close_out;
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task rst6;
      rst = 1;
      repeat (6) @(negedge clk);
      rst = 0;
   endtask
   // strobes held across exactly one rising edge; b asks for a write of bit s only
   task wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
      input logic [2:0] s = 3'h0);
      @(negedge clk);
      addr = a;
      wdata = d;
      bit_wr = b;
      bit_sel = s;
      wr_en = 1;
      @(negedge clk);
      wr_en = 0;
   endtask
   task rd(input string nm, input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd_en = 1;
      @(negedge clk);
      rd_en = 0;
      `CHK(nm, e, rdata_q)
   endtask
   // cycles until the next event of any kind, bounded
   task wt;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         if (n > 9000)
         begin
            failures++;
            close_out;
         end
      end while (!(interval_overflow_irq_q | nmi_req_q | sys_reset_req_q));
   endtask
   task t_regs;
      rd("ccs", 16'hff42, 8'h00);
      rd("mrr", 16'hfff9, 8'h00);
      wr(16'hff42, 8'h01, 1'b1, 3'h1);
      rd("ccs_no_bit", 16'hff42, 8'h00);
      wr(16'hff42, 8'hff);
      rd("ccs_bits", 16'hff42, 8'h06);
      wr(16'hfff9, 8'h01, 1'b1, 3'h3);
      rd("mrr_bit_set", 16'hfff9, 8'h08);
      wr(16'hfff9, 8'h00, 1'b1, 3'h3);
      rd("mrr_bit_clr", 16'hfff9, 8'h08);
      rd("unmapped", 16'h0000, 8'h00);
   endtask
   task t_interval;
      halt_mode = 1;
      wr(16'hff42, 8'h00);
      wr(16'hfff9, 8'h88);
      wt;
      wt;
      `CHK("period", 2048, n)
      `CHK("irq", 1'b1, interval_overflow_irq_q)
      halt_mode = 0;
      wr(16'hfff9, 8'h00);
      rd("sticky", 16'hfff9, 8'h88);
      // one full period each: masked, then stopped, then on the subsystem clock
      watchdog_irq_mask = 1;
      seen = 0;
      repeat (2100) @(negedge clk) seen |= interval_overflow_irq_q;
      `CHK("masked", 1'b0, seen)
      watchdog_irq_mask = 0;
      stop_mode = 1;
      seen = 0;
      repeat (2100) @(negedge clk) seen |= interval_overflow_irq_q;
      `CHK("stopped", 1'b0, seen)
      stop_mode = 0;
      sub_clk_cpu = 1;
      seen = 0;
      repeat (2100) @(negedge clk) seen |= interval_overflow_irq_q;
      `CHK("sub_clock", 1'b0, seen)
      sub_clk_cpu = 0;
   endtask
   task t_srst;
      rst6;
      // irq flag is low here, so choosing the watchdog mode must not raise a request
      wr(16'hfff9, 8'h98);
      wt;
      `CHK("srst", 1'b1, sys_reset_req_q)
      `CHK("first", 1'b1, 1'(n >= 2032 && n <= 2048))
   endtask
   // flag already pending when the watchdog mode is chosen
   task t_nmi;
      rst6;
      watchdog_irq_flag = 1;
      repeat (3) @(negedge clk);
      addr = 16'hfff9;
      wdata = 8'h10;
      wr_en = 1;
      @(negedge clk);
      wr_en = 0;
      seen = nmi_req_q;
      repeat (3) @(negedge clk) seen |= nmi_req_q;
      `CHK("late_nmi", 1'b1, seen)
      watchdog_irq_flag = 0;
      wr(16'hfff9, 8'h80);
      wt;
      `CHK("nmi", 1'b1, nmi_req_q)
   endtask
   initial
   begin
      rst6;
      t_regs;
      t_interval;
      t_srst;
      t_nmi;
      close_out;
   end
endmodule
